//--- logic/arsf_fifo.v
// Receive FIFO with pointer-equality full and empty detection
`default_nettype none
`include "arsf_regs.vh"
module arsf_fifo #(
  parameter WIDTH = `ARSF_DATA_WIDTH,
  parameter DEPTH = `ARSF_FIFO_DEPTH,
  parameter AW = `ARSF_FIFO_AW
) (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire in_valid_i,
  input wire [WIDTH-1:0] in_data_i,
  output wire in_ready_o,
  output wire out_valid_o,
  output wire [WIDTH-1:0] out_data_o,
  input wire out_ready_i,
  output wire full_o,
  output wire empty_o,
  output wire [AW:0] count_o
);
  // ===========================================
  // Storage and pointers
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] receive_write_pointer;
  reg [AW-1:0] receive_read_pointer;
  reg last_was_write;
  wire ptr_equal;
  wire push;
  wire pop;
  wire [AW-1:0] ptr_diff;

  assign ptr_equal = (receive_write_pointer == receive_read_pointer);
  assign full_o = ptr_equal & last_was_write;
  assign empty_o = ptr_equal & ~last_was_write;
  assign in_ready_o = ~full_o;
  assign out_valid_o = ~empty_o;
  assign out_data_o = mem[receive_read_pointer];
  assign push = ce_i & in_valid_i & ~full_o;
  assign pop = ce_i & out_ready_i & ~empty_o;
  assign ptr_diff = receive_write_pointer - receive_read_pointer;
  assign count_o = full_o ? {1'b1, {AW{1'b0}}} : {1'b0, ptr_diff};

  // ===========================================
  // Write side
  always @(posedge ref_clk_i) begin
    if (push) begin
      mem[receive_write_pointer] <= in_data_i;
    end
  end

  // ===========================================
  // Pointer and access tracking
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      receive_write_pointer <= {AW{1'b0}};
      receive_read_pointer <= {AW{1'b0}};
      last_was_write <= 1'b0;
    end else if (ce_i) begin
      if (push) begin
        receive_write_pointer <= receive_write_pointer + 1'b1;
      end
      if (pop) begin
        receive_read_pointer <= receive_read_pointer + 1'b1;
      end
      if (push && !pop) begin
        last_was_write <= 1'b1;
      end else if (pop && !push) begin
        last_was_write <= 1'b0;
      end
    end
  end
endmodule // arsf_fifo
`default_nettype wire

//--- logic/arsf_regs.vh
// Constants for the receive FIFO status and control block
`ifndef ARSF_REGS_VH
`define ARSF_REGS_VH
// Notes on behaviour
// - Reset loads status/control with 0004h.
// - CPU reads and writes status/control.
// - Almost-full set when count equals warning level.
// - Full when pointers equal, last access write.
// - Empty when pointers equal, last access read.
// - Overflow set when word arrives while full.
// - Overflowing word discarded, no request raised.
// ===========================================
// Register layout
`define ARSF_REG_WIDTH 16
`define ARSF_RESET_VALUE 16'h0004
`define ARSF_ALMOST_FULL_BIT 0
`define ARSF_FULL_BIT 1
`define ARSF_EMPTY_BIT 2
`define ARSF_OVERFLOW_BIT 3
`define ARSF_SLOT_LSB 4
`define ARSF_SLOT_MSB 11
`define ARSF_LEVEL_LSB 12
`define ARSF_LEVEL_MSB 15
// ===========================================
// FIFO shape
`define ARSF_FIFO_DEPTH 8
`define ARSF_FIFO_AW 3
`define ARSF_DATA_WIDTH 16
`endif

//--- logic/arsf_rx_status.v
// Receive status/control register and receive FIFO front end
`default_nettype none
`include "arsf_regs.vh"
module arsf_rx_status #(
  parameter WIDTH = `ARSF_DATA_WIDTH,
  parameter DEPTH = `ARSF_FIFO_DEPTH,
  parameter AW = `ARSF_FIFO_AW
) (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire audio_clock_gate_i,
  input wire shift_word_valid_i,
  input wire [WIDTH-1:0] shift_word_i,
  input wire ctrl_wr_i,
  input wire [`ARSF_REG_WIDTH-1:0] ctrl_wdata_i,
  input wire ctrl_rd_i,
  output reg [`ARSF_REG_WIDTH-1:0] ctrl_rdata_o,
  input wire data_rd_i,
  output reg [WIDTH-1:0] data_rdata_o,
  output reg data_valid_o,
  output reg receive_request_o,
  output reg overflow_pulse_o
);
  // ===========================================
  // Helper functions
  function level_hit;
    input [AW:0] count;
    input [3:0] level;
    begin
      level_hit = ({1'b0, count} == {1'b0, level});
    end
  endfunction

  function above_level;
    input [AW:0] count;
    input [3:0] level;
    begin
      above_level = ({1'b0, count} > {1'b0, level});
    end
  endfunction

  // ===========================================
  // Declarations
  wire ce;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [WIDTH-1:0] fifo_out_data;
  wire fifo_full;
  wire fifo_empty;
  wire [AW:0] fifo_count;
  wire word_arrives;
  wire overflow_event;
  wire accept_event;
  wire pop_event;
  wire overflow_clear;
  wire [AW:0] next_count;
  reg receive_almost_full_flag;
  reg receive_full_flag;
  reg receive_empty_flag;
  reg receive_overflow_flag;
  reg [`ARSF_SLOT_MSB-`ARSF_SLOT_LSB:0] slot_field;
  reg [3:0] receive_warning_level;
  reg next_almost_full;
  reg next_overflow;
  reg [`ARSF_REG_WIDTH-1:0] status_word;

  // ===========================================
  // Clock gating of all state
  // state held while gated
  assign ce = audio_clock_gate_i;

  // ===========================================
  // Event decode
  assign word_arrives = ce & shift_word_valid_i;
  assign overflow_event = word_arrives & fifo_full;
  assign accept_event = word_arrives & fifo_in_ready;
  assign pop_event = ce & data_rd_i & fifo_out_valid;
  assign next_count = fifo_count + {{AW{1'b0}}, accept_event} - {{AW{1'b0}}, pop_event};
  assign overflow_clear = ce & ctrl_wr_i & ctrl_wdata_i[`ARSF_OVERFLOW_BIT];

  // ===========================================
  // Receive FIFO
  arsf_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH),
    .AW(AW)
  ) arsf_fifo_i (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce),
    .in_valid_i(shift_word_valid_i),
    .in_data_i(shift_word_i),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(fifo_out_valid),
    .out_data_o(fifo_out_data),
    .out_ready_i(data_rd_i),
    .full_o(fifo_full),
    .empty_o(fifo_empty),
    .count_o(fifo_count)
  );

  // ===========================================
  // Next flag values
  always @* begin
    next_almost_full = level_hit(fifo_count, receive_warning_level);
    next_overflow = receive_overflow_flag;
    if (overflow_clear) begin
      next_overflow = 1'b0;
    end
    if (overflow_event) begin
      next_overflow = 1'b1;
    end
  end

  // ===========================================
  // Status flags
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      receive_almost_full_flag <= 1'b0;
      receive_full_flag <= 1'b0;
      receive_empty_flag <= 1'b1;
      receive_overflow_flag <= 1'b0;
    end else if (ce) begin
      receive_almost_full_flag <= next_almost_full;
      receive_full_flag <= fifo_full;
      receive_empty_flag <= fifo_empty;
      receive_overflow_flag <= next_overflow;
    end
  end

  // ===========================================
  // Writable control fields
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      slot_field <= {(`ARSF_SLOT_MSB-`ARSF_SLOT_LSB+1){1'b0}};
      receive_warning_level <= 4'h0;
    end else if (ce && ctrl_wr_i) begin
      slot_field <= ctrl_wdata_i[`ARSF_SLOT_MSB:`ARSF_SLOT_LSB];
      receive_warning_level <= ctrl_wdata_i[`ARSF_LEVEL_MSB:`ARSF_LEVEL_LSB];
    end
  end

  // ===========================================
  // Register image
  always @* begin
    status_word = {`ARSF_REG_WIDTH{1'b0}};
    status_word[`ARSF_ALMOST_FULL_BIT] = receive_almost_full_flag;
    status_word[`ARSF_FULL_BIT] = receive_full_flag;
    status_word[`ARSF_EMPTY_BIT] = receive_empty_flag;
    status_word[`ARSF_OVERFLOW_BIT] = receive_overflow_flag;
    status_word[`ARSF_SLOT_MSB:`ARSF_SLOT_LSB] = slot_field;
    status_word[`ARSF_LEVEL_MSB:`ARSF_LEVEL_LSB] = receive_warning_level;
  end

  // ===========================================
  // Register read port
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ctrl_rdata_o <= `ARSF_RESET_VALUE;
    end else if (ce && ctrl_rd_i) begin
      ctrl_rdata_o <= status_word;
    end
  end

  // ===========================================
  // Receive data read port
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      data_rdata_o <= {WIDTH{1'b0}};
      data_valid_o <= 1'b0;
    end else if (ce) begin
      data_valid_o <= pop_event;
      if (pop_event) begin
        data_rdata_o <= fifo_out_data;
      end
    end
  end

  // ===========================================
  // Receive request and overflow event
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      receive_request_o <= 1'b0;
      overflow_pulse_o <= 1'b0;
    end else if (ce) begin
      receive_request_o <= above_level(next_count, receive_warning_level);
      overflow_pulse_o <= overflow_event;
    end
  end
endmodule // arsf_rx_status
`default_nettype wire

//--- tb/arsf_rx_monitor.sv
// Checker for the receive status block ports
`default_nettype none
module arsf_rx_monitor (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic audio_clock_gate_i,
  input wire logic shift_word_valid_i,
  input wire logic ctrl_wr_i,
  input wire logic ctrl_rd_i,
  input wire logic [15:0] ctrl_rdata_o,
  input wire logic data_rd_i,
  input wire logic [15:0] data_rdata_o,
  input wire logic data_valid_o,
  input wire logic receive_request_o,
  input wire logic overflow_pulse_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ====
  // Properties
  property p_rst; $rose(rst_n_i) |-> ctrl_rdata_o == 16'h0004; endproperty
  a_rst: assert property (p_rst) else $error("bad reset image");
  property p_hold; !(ctrl_rd_i && audio_clock_gate_i) |=> $stable(ctrl_rdata_o); endproperty
  a_hold: assert property (p_hold) else $error("image moved");
  property p_gate;
    !audio_clock_gate_i |=> $stable(data_valid_o) && $stable(overflow_pulse_o)
      && $stable(receive_request_o) && $stable(ctrl_rdata_o);
  endproperty
  a_gate: assert property (p_gate) else $error("gated activity");
  property p_excl; !(ctrl_rdata_o[1] && ctrl_rdata_o[2]); endproperty
  a_excl: assert property (p_excl) else $error("full and empty");
  property p_dv;
    data_valid_o |-> $past(data_rd_i) && $past(audio_clock_gate_i);
  endproperty
  a_dv: assert property (p_dv) else $error("pop without read");
  property p_dhold; !data_valid_o |-> $stable(data_rdata_o); endproperty
  a_dhold: assert property (p_dhold) else $error("data moved");
  property p_ovf;
    overflow_pulse_o |-> $past(shift_word_valid_i) && $past(audio_clock_gate_i);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow without word");
  property p_ovf_req;
    overflow_pulse_o && !$past(data_rd_i) && !$past(ctrl_wr_i, 2)
      |-> $stable(receive_request_o);
  endproperty
  a_ovf_req: assert property (p_ovf_req) else $error("overflow moved request");
  property p_req;
    $rose(receive_request_o) |-> $past(audio_clock_gate_i)
      && ($past(shift_word_valid_i) || $past(ctrl_wr_i, 2));
  endproperty
  a_req: assert property (p_req) else $error("request rose alone");
endmodule // arsf_rx_monitor
bind arsf_rx_status arsf_rx_monitor arsf_rx_monitor_i (.ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i), .audio_clock_gate_i(audio_clock_gate_i),
  .shift_word_valid_i(shift_word_valid_i), .ctrl_wr_i(ctrl_wr_i), .ctrl_rd_i(ctrl_rd_i),
  .ctrl_rdata_o(ctrl_rdata_o), .data_rd_i(data_rd_i), .data_rdata_o(data_rdata_o),
  .data_valid_o(data_valid_o), .receive_request_o(receive_request_o),
  .overflow_pulse_o(overflow_pulse_o));
`default_nettype wire

//--- tb/arsf_rx_status_tb_top.sv
// Testbench for the receive status block
`default_nettype none
module arsf_rx_status_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic gate = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic drd = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic sv;
  logic [15:0] sw;
  logic [15:0] rdata;
  logic [15:0] drdata;
  logic dvalid;
  logic req;
  logic ovp;
  logic [15:0] got;
  int n_errors = 0;
  int n_compared = 0;
  always #2 ref_clk_i = ~ref_clk_i;
  arsf_rx_status arsf_rx_status_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .audio_clock_gate_i(gate), .shift_word_valid_i(sv), .shift_word_i(sw),
    .ctrl_wr_i(wr), .ctrl_wdata_i(wdata), .ctrl_rd_i(rd), .ctrl_rdata_o(rdata),
    .data_rd_i(drd), .data_rdata_o(drdata), .data_valid_o(dvalid),
    .receive_request_o(req), .overflow_pulse_o(ovp));
  arsf_shift_model arsf_shift_model_i (.clk_i(ref_clk_i), .valid_o(sv), .word_o(sw));
  // ====
  // Tasks
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic ctrl_write(input logic [15:0] v);
    @(posedge ref_clk_i);
    wr <= 1'b1;
    wdata <= v;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask
  task automatic ctrl_check(input logic [15:0] e, input logic er);
    @(posedge ref_clk_i);
    rd <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1;
    cmp(rdata, e);
    cmp({15'h0000, req}, {15'h0000, er});
  endtask
  task automatic data_read(input logic [15:0] e, input logic ev);
    @(posedge ref_clk_i);
    drd <= 1'b1;
    @(posedge ref_clk_i);
    drd <= 1'b0;
    #1;
    cmp({15'h0000, dvalid}, {15'h0000, ev});
    cmp(drdata, e);
  endtask
  task automatic tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ====
  // Tests
  initial begin
    tick(6);
    rst_n_i <= 1'b1;
    tick(1);
    #1;
    cmp(rdata, 16'h0004);
    ctrl_check(16'h0005, 1'b0);
    ctrl_write(16'h3A5F);
    ctrl_check(16'h3A54, 1'b0);
    $display("test register done");
    arsf_shift_model_i.burst(16'hC000, 3);
    tick(3);
    ctrl_check(16'h3A51, 1'b0);
    arsf_shift_model_i.burst(16'hC003, 1);
    #1;
    cmp({15'h0000, ovp}, 16'h0000);
    tick(3);
    ctrl_check(16'h3A50, 1'b1);
    arsf_shift_model_i.burst(16'hC004, 4);
    tick(3);
    ctrl_check(16'h3A52, 1'b1);
    arsf_shift_model_i.burst(16'hFFFF, 1);
    #1;
    cmp({15'h0000, ovp}, 16'h0001);
    tick(3);
    ctrl_check(16'h3A5A, 1'b1);
    $display("test fill done");
    for (int i = 0; i < 8; i++) begin
      data_read(16'hC000 + 16'(i), 1'b1);
    end
    tick(2);
    ctrl_check(16'h3A5C, 1'b0);
    ctrl_write(16'h3A58);
    ctrl_check(16'h3A54, 1'b0);
    data_read(16'hC007, 1'b0);
    $display("test drain done");
    @(posedge ref_clk_i);
    gate <= 1'b0;
    ctrl_write(16'h0000);
    arsf_shift_model_i.burst(16'h1234, 1);
    @(posedge ref_clk_i);
    gate <= 1'b1;
    ctrl_check(16'h3A54, 1'b0);
    $display("test gate done");
    arsf_shift_model_i.burst(16'h5000, 1);
    fork
      arsf_shift_model_i.burst(16'h5001, 1);
      data_read(16'h5000, 1'b1);
    join
    ctrl_check(16'h3A50, 1'b0);
    data_read(16'h5001, 1'b1);
    ctrl_check(16'h3A54, 1'b0);
    $display("test same cycle done");
    tally_and_finish();
  end
  initial begin
    #4000;
    n_errors++;
    tally_and_finish();
  end
endmodule // arsf_rx_status_tb_top
`default_nettype wire

//--- tb/arsf_shift_model.sv
// Receive shifter model delivering completed words
`default_nettype none
module arsf_shift_model (
  input wire logic clk_i,
  output var logic valid_o,
  output var logic [15:0] word_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    valid_o = 1'b0;
    word_o = 16'h0000;
  end
  // ====
  // Burst of words
  task automatic burst(input logic [15:0] base, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      valid_o <= 1'b1;
      word_o <= base + 16'(i);
    end
    @(posedge clk_i);
    valid_o <= 1'b0;
    word_o <= ~word_o;
  endtask
endmodule // arsf_shift_model
`default_nettype wire
